// ### shared/clk_default_map.svh
// Constants for the output clock reset default decoder.
// Assumes inclusion by the design file only; the package holds the types.
`ifndef CLK_DEFAULT_MAP_SVH
`define CLK_DEFAULT_MAP_SVH
`define STRAP_001 3'h1
`define STRAP_010 3'h2
`define MAIN_MODE_E1 3'h2
`define MAIN_MODE_DS1 3'h4
`define MAIN_MODE_SONET 3'h1
`define AUX_MODE_E3 4'h6
`define AUX_MODE_DS3 4'h7
`define AUX_MODE_E1 4'h3
`define AUX_MODE_DS1 4'h5
`define FREQ_OFF 4'h0
`define FREQ_AUX_DIV4 4'hF
`define FREQ_AUX_DIV8 4'hE
`define FREQ_AUX_DIV16 4'hD
`define FREQ_MAIN_DIV2 4'h3
`define FREQ_MAIN_DIV16 4'h6
`define FREQ_MAIN_DIV12 4'h7
`define FREQ_MAIN_DIV8 4'h8
`define FREQ_MAIN_DIV6 4'h9
`define FREQ_MAIN_DIV4 4'hA
`define FLOAT_B 3'h4
`define FLOAT_A 3'h3
`endif

// ### shared/clk_default_pkg.sv
// Types for the output clock reset default decoder.
// Assumes nothing beyond the map header.
package clk_default_pkg;
   typedef struct packed {
      logic [2:0] main_pll_freq_mode;
      logic [3:0] aux_pll_freq_mode;
      logic [3:0] out_a_freq_code;
      logic [3:0] out_b_freq_code;
   } freq_fields_t;
   typedef struct packed {
      logic main_pll;
      logic aux_pll;
      logic out_a;
      logic out_b;
   } field_wr_t;
endpackage : clk_default_pkg

// ### rtl/output_clock_reset_default_decoder.sv
// Strap decoder and holder of the four frequency fields.
// Assumes straps are stable and synchronous through reset and one edge after it.
`timescale 1ns/1ns
`default_nettype none
`include "clk_default_map.svh"
module output_clock_reset_default_decoder
   import clk_default_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [2:0] out_a_default_straps_i,
   input wire logic [2:0] out_b_default_straps_i,
   input wire logic rate_family_strap_i,
   input wire field_wr_t wr_en_i,
   input wire freq_fields_t wr_data_i,
   output freq_fields_t fields_o
);
   // Strap group compare shared by the main, aux and output A decodes below
   function automatic logic strap_is(input logic [2:0] pins, input logic [2:0] code);
      return pins == code;
   endfunction : strap_is

   // Aux PLL at divide 4 or 8 by rate family; either output may take it
   function automatic logic [3:0] aux_pair_code(input logic r);
      logic [3:0] code;
      code = `FREQ_AUX_DIV4;
      if (r) begin
         code = `FREQ_AUX_DIV8;
      end
      return code;
   endfunction : aux_pair_code

   // Main PLL leaves the SONET rate only when both straps are 001
   function automatic logic [2:0] main_mode_default(input logic [2:0] a, input logic [2:0] b,
                                                    input logic r);
      logic [2:0] mode;
      mode = `MAIN_MODE_SONET;
      if (strap_is(a, `STRAP_001) && strap_is(b, `STRAP_001)) begin
         if (r) begin
            mode = `MAIN_MODE_DS1;
         end else begin
            mode = `MAIN_MODE_E1;
         end
      end
      return mode;
   endfunction : main_mode_default

   // Aux PLL runs E3 or DS3 when B straps 001 or A straps 010; A's aux divide 16 at 001 keeps E1 or DS1
   function automatic logic [3:0] aux_mode_default(input logic [2:0] a, input logic [2:0] b,
                                                   input logic r);
      logic [3:0] mode;
      mode = `AUX_MODE_E1;
      if (strap_is(b, `STRAP_001) || strap_is(a, `STRAP_010)) begin
         if (r) begin
            mode = `AUX_MODE_DS3;
         end else begin
            mode = `AUX_MODE_E3;
         end
      end else begin
         if (r) begin
            mode = `AUX_MODE_DS1;
         end else begin
            mode = `AUX_MODE_E1;
         end
      end
      return mode;
   endfunction : aux_mode_default

   // Output B: 001 borrows the aux PLL, every other enabled code the main PLL
   function automatic logic [3:0] out_b_default(input logic [2:0] b, input logic r);
      logic [3:0] code;
      code = `FREQ_OFF;
      case (b)
         3'h0: begin
            code = `FREQ_OFF;
         end
         3'h1: begin
            code = aux_pair_code(r);
         end
         3'h2: begin
            code = `FREQ_MAIN_DIV16;
         end
         3'h3: begin
            code = `FREQ_MAIN_DIV12;
         end
         3'h4: begin
            code = `FREQ_MAIN_DIV8;
         end
         3'h5: begin
            code = `FREQ_MAIN_DIV6;
         end
         3'h6: begin
            code = `FREQ_MAIN_DIV4;
         end
         default: begin
            code = `FREQ_MAIN_DIV2;
         end
      endcase
      return code;
   endfunction : out_b_default

   // Output A: 001 gives way to output B when B already holds the aux PLL
   function automatic logic [3:0] out_a_default(input logic [2:0] a, input logic [2:0] b,
                                                input logic r);
      logic [3:0] code;
      code = `FREQ_OFF;
      case (a)
         3'h0: begin
            code = `FREQ_OFF;
         end
         3'h1: begin
            if (strap_is(b, `STRAP_001)) begin
               code = `FREQ_MAIN_DIV12;
            end else begin
               code = `FREQ_AUX_DIV16;
            end
         end
         3'h2: begin
            code = aux_pair_code(r);
         end
         3'h3: begin
            code = `FREQ_MAIN_DIV16;
         end
         3'h4: begin
            code = `FREQ_MAIN_DIV12;
         end
         3'h5: begin
            code = `FREQ_MAIN_DIV8;
         end
         3'h6: begin
            code = `FREQ_MAIN_DIV6;
         end
         default: begin
            code = `FREQ_MAIN_DIV4;
         end
      endcase
      return code;
   endfunction : out_a_default

   // Async reset loads constants only, so the straps are decoded on the
   // first clock edge after release; a write on that edge is lost
   logic decode_pend_q;
   logic decode_pend_d;
   logic [2:0] main_mode_q;
   logic [2:0] main_mode_d;
   logic [3:0] aux_mode_q;
   logic [3:0] aux_mode_d;
   logic [3:0] out_a_code_q;
   logic [3:0] out_a_code_d;
   logic [3:0] out_b_code_q;
   logic [3:0] out_b_code_d;

   // One-shot decode flag
   always_comb begin
      decode_pend_d = 1'b0;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         decode_pend_q <= 1'b1;
      end else begin
         decode_pend_q <= decode_pend_d;
      end
   end

   // Main PLL mode
   always_comb begin
      main_mode_d = main_mode_q;
      if (decode_pend_q) begin
         main_mode_d = main_mode_default(out_a_default_straps_i, out_b_default_straps_i,
                                         rate_family_strap_i);
      end else if (wr_en_i.main_pll) begin
         // Straps unread past the decode edge; pins are free for other use
         main_mode_d = wr_data_i.main_pll_freq_mode;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         main_mode_q <= `MAIN_MODE_SONET;
      end else begin
         main_mode_q <= main_mode_d;
      end
   end

   // Aux PLL mode
   always_comb begin
      aux_mode_d = aux_mode_q;
      if (decode_pend_q) begin
         aux_mode_d = aux_mode_default(out_a_default_straps_i, out_b_default_straps_i,
                                       rate_family_strap_i);
      end else if (wr_en_i.aux_pll) begin
         aux_mode_d = wr_data_i.aux_pll_freq_mode;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aux_mode_q <= `AUX_MODE_E1;
      end else begin
         aux_mode_q <= aux_mode_d;
      end
   end

   // Output A code
   always_comb begin
      out_a_code_d = out_a_code_q;
      if (decode_pend_q) begin
         out_a_code_d = out_a_default(out_a_default_straps_i, out_b_default_straps_i,
                                      rate_family_strap_i);
      end else if (wr_en_i.out_a) begin
         out_a_code_d = wr_data_i.out_a_freq_code;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_a_code_q <= `FREQ_MAIN_DIV16;
      end else begin
         out_a_code_q <= out_a_code_d;
      end
   end

   // Output B code
   always_comb begin
      out_b_code_d = out_b_code_q;
      if (decode_pend_q) begin
         out_b_code_d = out_b_default(out_b_default_straps_i, rate_family_strap_i);
      end else if (wr_en_i.out_b) begin
         out_b_code_d = wr_data_i.out_b_freq_code;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_b_code_q <= `FREQ_MAIN_DIV8;
      end else begin
         out_b_code_q <= out_b_code_d;
      end
   end

   // Fields go out straight from their flops, no logic in between
   assign fields_o = {main_mode_q, aux_mode_q, out_a_code_q, out_b_code_q};
endmodule : output_clock_reset_default_decoder
`default_nettype wire

// ### test/decoder_properties.sv
// Port checker for the strap decoder.
// Bound to every decoder instance; needs only its ports.
`timescale 1ns/1ns
`default_nettype none
module decoder_properties import clk_default_pkg::*; (
input wire logic clk_i,
input wire logic nrst_i,
input wire logic [2:0] out_a_default_straps_i,
input wire logic [2:0] out_b_default_straps_i,
input wire logic rate_family_strap_i,
input wire field_wr_t wr_en_i,
input wire freq_fields_t wr_data_i,
input wire freq_fields_t fields_o);
logic up_q;
always_ff @(posedge clk_i or negedge nrst_i) if (!nrst_i) up_q <= 1'b0; else up_q <= 1'b1;
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
// First edge after release is the decode edge
sequence dec_s; !up_q && out_b_default_straps_i == 3'h1; endsequence
hold_idle_a:
assert property (up_q && wr_en_i == 4'h0 |=> $stable(fields_o)) else $error("moved");
main_wr_a:
assert property (up_q && wr_en_i[3] |=> fields_o[14:12] == $past(wr_data_i[14:12])) else $error("m");
b_wr_a:
assert property (up_q && wr_en_i[0] |=> fields_o[3:0] == $past(wr_data_i[3:0])) else $error("b");
b_dflt_a:
assert property (dec_s |=> fields_o[3:0] == {3'h7, !$past(rate_family_strap_i)}) else $error("bd");
main_dflt_a:
assert property (dec_s ##0 out_a_default_straps_i == 3'h1
   |=> fields_o[14:12] == ($past(rate_family_strap_i) ? 3'h4 : 3'h2)) else $error("md");
rst_dflt_a:
assert property (disable iff (1'b0) !nrst_i |-> fields_o == 15'h1368) else $error("rd");
// Any first edge after release, whatever the straps
sequence dec_edge_s; !up_q; endsequence
aux_wr_a:
assert property (up_q && wr_en_i[2] |=> fields_o[11:8] == $past(wr_data_i[11:8]))
   else $error("aux write lost");
a_wr_a:
assert property (up_q && wr_en_i[1] |=> fields_o[7:4] == $past(wr_data_i[7:4]))
   else $error("out a write lost");
aux_dflt_a:
assert property (dec_edge_s ##0 (out_b_default_straps_i == 3'h1 || out_a_default_straps_i == 3'h2)
   |=> fields_o[11:8] == {3'h3, $past(rate_family_strap_i)}) else $error("aux default wrong");
a_top_dflt_a:
assert property (dec_edge_s ##0 out_a_default_straps_i == 3'h7 |=> fields_o[7:4] == 4'hA)
   else $error("out a default wrong");
endmodule : decoder_properties
bind output_clock_reset_default_decoder decoder_properties props_i(.*);
`default_nettype wire

// ### test/strap_board.sv
// Board strap model: fixed levels in reset, GPIO traffic after.
// Assumes the bench raises gpio_i only once the decode edge has passed.
`timescale 1ns/1ns
`default_nettype none
module strap_board (
input wire logic clk_i,
input wire logic gpio_i,
input wire logic [6:0] set_i,
output var logic [6:0] pins_o = 7'h00);
// Reused pins toggle freely while gpio_i is high, which the bench sets after the decode edge
always @(negedge clk_i) pins_o <= gpio_i ? 7'($urandom) : set_i;
endmodule : strap_board
`default_nettype wire

// ### test/output_clock_reset_default_decoder_test.sv
// Bench for the strap decoder; all 128 strap sets, then random writes.
// Assumes the strap board model and the bound port checker alongside.
`timescale 1ns/1ns
`default_nettype none
module output_clock_reset_default_decoder_test;
import clk_default_pkg::*;
logic clk_i = 0, nrst_i = 1, gpio = 0;
logic [6:0] set = 0, pins;
field_wr_t wr_en_i = '0;
freq_fields_t wr_data_i = '0, fields_o, exp, m;
int err_count = 0, n_tests = 0, cyc = 0;
int ta[8] = '{0, 0, 0, 6, 7, 8, 9, 10}, tb[8] = '{0, 0, 6, 7, 8, 9, 10, 3};
always #10 clk_i = ~clk_i;
always @(posedge clk_i) if (++cyc > 3000) begin err_count++; conclude(); end
strap_board sb(.clk_i(clk_i), .gpio_i(gpio), .set_i(set), .pins_o(pins));
output_clock_reset_default_decoder uut(.clk_i(clk_i), .nrst_i(nrst_i),
   .out_a_default_straps_i(pins[2:0]), .out_b_default_straps_i(pins[5:3]),
   .rate_family_strap_i(pins[6]), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .fields_o(fields_o));
task chk(input freq_fields_t s, input freq_fields_t e);
   n_tests++;
   if (s !== e) begin err_count++; $display("Error %0t %h %h", $time, s, e); end
endtask : chk
task conclude;
   if (err_count == 0 && n_tests > 0) $display("Regression OK");
   else $display("Regression broken");
   $finish;
endtask : conclude
initial begin
   logic [2:0] a, b;
   logic r;
   void'($urandom(32'h7280b65f));
   for (int k = 0; k < 128; k++) begin
      @(negedge clk_i) nrst_i = 0;
      gpio <= 0;
      set <= 7'(k);
      wr_en_i = '0;
      repeat (4) @(negedge clk_i);
      chk(fields_o, 15'h1368);
      {r, b, a} = 7'(k);
      nrst_i = 1;
      exp[14:12] = (a == 1 && b == 1) ? (r ? 3'h4 : 3'h2) : 3'h1;
      exp[11:8] = (b == 1 || a == 2) ? {3'h3, r} : (r ? 4'h5 : 4'h3);
      exp[3:0] = b == 1 ? {3'h7, ~r} : 4'(tb[b]);
      exp[7:4] = a == 1 ? (b == 1 ? 4'h7 : 4'hD) : a == 2 ? {3'h7, ~r} : 4'(ta[a]);
      // Straps must stay put through the decode edge
      @(negedge clk_i) gpio <= 1;
      chk(fields_o, exp);
      repeat (3) begin
         wr_en_i = field_wr_t'(4'($urandom));
         wr_data_i = freq_fields_t'(15'($urandom));
         m = {{3{wr_en_i[3]}}, {4{wr_en_i[2]}}, {4{wr_en_i[1]}}, {4{wr_en_i[0]}}};
         exp = (exp & ~m) | (wr_data_i & m);
         @(negedge clk_i);
         chk(fields_o, exp);
      end
   end
   conclude();
end
endmodule : output_clock_reset_default_decoder_test
`default_nettype wire
